// ==== core/pmrc_top.sv ====
`timescale 1ns/100ps
module pmrc_top
  import pmrc_pkg::*;
#(
  parameter int STARTUP_CYC = STARTUP_CYC_DEF
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Register port.
  input wire pmrc_bus_s bus_i,
  output logic [DATA_W-1:0] rdata_o,
  // Analog and event inputs.
  input wire logic [NUM_LEVELS-1:0] vcc_below_i,
  input wire pmrc_rst_src_s rst_src_i,
  input wire logic multi_input_wakeup_i,
  input wire logic osc_tick_i,
  input wire logic ext_clock_in_i,
  // Control outputs.
  output logic core_run_o,
  output logic io_reset_o,
  output logic osc_en_o,
  output logic lvd_en_o,
  output logic bod_en_o,
  output logic timer0_en_o,
  output logic instr_tick_o,
  output logic ext_clock_out_o
);

  typedef struct packed {
    pmrc_state_e state;
    logic [CNT_W-1:0] cnt;
    logic [1:0] div;
    logic ext_q;
    logic [TMR_W-1:0] tmr;
    logic [LB_TRIM_W-1:0] trim;
    logic [CSEL_W-1:0] csel;
    logic flag;
    logic halt_req;
    logic idle_req;
    logic [DATA_W-1:0] rdata;
    logic core_run;
    logic io_reset;
    logic osc_en;
    logic lvd_en;
    logic bod_en;
    logic tmr_en;
    logic tick;
    logic xdrv;
  } pmrc_st_s;

  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(STARTUP_CYC - 1);

  pmrc_st_s st_r;
  pmrc_st_s st_nxt;
  logic any_rst;
  logic ext_rise;
  logic clk_act;
  logic ovf;

  always_comb begin
    st_nxt = st_r;
    // Any source forces the sequence.
    // reset source merge
    any_rst = rst_src_i.por | rst_src_i.brownout_reset | rst_src_i.wdog |
              ~rst_src_i.ext_reset_b;
    ext_rise = ext_clock_in_i & ~st_r.ext_q;
    st_nxt.ext_q = ext_clock_in_i;
    clk_act = (st_r.state == ST_RUN) || (st_r.state == ST_IDLE);
    // Instruction clock generation.
    st_nxt.tick = 1'b0;
    if (clk_act) begin
      case (st_r.csel)
        CSEL_INT: begin
          if (osc_tick_i) begin
            st_nxt.div = (st_r.div == DIV_INT_LAST) ? DIV_ZERO :
                         st_r.div + 2'h1;
            st_nxt.tick = (st_r.div == DIV_INT_LAST);
          end
        end
        CSEL_SQUARE: begin
          st_nxt.tick = ext_rise;
        end
        // crystal and RC divide by four
        default: begin
          if (ext_rise) begin
            st_nxt.div = st_r.div + 2'h1;
            st_nxt.tick = (st_r.div == DIV_EXT_LAST);
          end
        end
      endcase
    end
    // Timer 0 counts instruction cycles.
    ovf = st_nxt.tick && (st_r.tmr == TMR_LAST);
    if (st_nxt.tick) begin
      st_nxt.tmr = st_r.tmr + 13'h0001;
    end
    // Comparator path; holds while the detector is off.
    // flag tracks comparator
    if (st_r.lvd_en) begin
      st_nxt.flag = vcc_below_i[st_r.trim];
    end
    // Register writes.
    if (bus_i.wr) begin
      case (bus_i.addr)
        OFF_LBAT_CTRL: begin
          st_nxt.trim = bus_i.wdata[LB_TRIM_LSB +: LB_TRIM_W];
        end
        OFF_PWR_REQ: begin
          if (st_r.state == ST_RUN) begin
            st_nxt.halt_req = bus_i.wdata[HALT_REQ_BIT];
            st_nxt.idle_req = bus_i.wdata[IDLE_REQ_BIT] &
                              ~bus_i.wdata[HALT_REQ_BIT];
          end
        end
        OFF_CLK_SEL: begin
          st_nxt.csel = bus_i.wdata[CSEL_W-1:0];
          st_nxt.div = DIV_ZERO;
        end
        default: begin
        end
      endcase
    end
    // Register reads; unmapped and write-only offsets read zero.
    st_nxt.rdata = DATA_ZERO;
    if (bus_i.rd) begin
      case (bus_i.addr)
        OFF_LBAT_CTRL: begin
          st_nxt.rdata[LB_FLAG_BIT] = st_r.flag;
          st_nxt.rdata[LB_TRIM_LSB +: LB_TRIM_W] = st_r.trim;
        end
        OFF_CLK_SEL: begin
          st_nxt.rdata[CSEL_W-1:0] = st_r.csel;
        end
        OFF_STATUS: begin
          st_nxt.rdata[$bits(pmrc_state_e)-1:0] = st_r.state;
        end
        default: begin
        end
      endcase
    end
    // Power mode sequencing.
    case (st_r.state)
      ST_RESET: begin
        if (any_rst) begin
          st_nxt.cnt = CNT_LOAD;
        end else if (st_r.cnt == CNT_ZERO) begin
          st_nxt.state = ST_RUN;
        end else begin
          st_nxt.cnt = st_r.cnt - 17'h00001;
        end
      end
      ST_RUN: begin
        if (st_nxt.halt_req) begin
          st_nxt.state = ST_HALT;
        end else if (st_nxt.idle_req) begin
          st_nxt.state = ST_IDLE;
        end
      end
      ST_HALT: begin
        if (multi_input_wakeup_i) begin
          st_nxt.state = ST_HWAKE;
          st_nxt.cnt = CNT_LOAD;
        end
      end
      ST_HWAKE: begin
        if (st_r.cnt == CNT_ZERO) begin
          st_nxt.state = ST_RUN;
          st_nxt.halt_req = 1'b0;
        end else begin
          st_nxt.cnt = st_r.cnt - 17'h00001;
        end
      end
      ST_IDLE: begin
        if (ovf) begin
          st_nxt.state = ST_RUN;
          st_nxt.idle_req = 1'b0;
        end
      end
      default: begin
        st_nxt.state = ST_RESET;
      end
    endcase
    if (any_rst) begin
      st_nxt.state = ST_RESET;
      st_nxt.cnt = CNT_LOAD;
      st_nxt.halt_req = 1'b0;
      st_nxt.idle_req = 1'b0;
      st_nxt.trim = TRIM_RST;
      st_nxt.csel = CSEL_INT;
      st_nxt.div = DIV_ZERO;
      st_nxt.tmr = TMR_ZERO;
    end
    // Outputs follow the next state so they line up with it.
    st_nxt.core_run = (st_nxt.state == ST_RUN);
    st_nxt.io_reset = (st_nxt.state == ST_RESET);
    // oscillator on unless halted or external
    st_nxt.osc_en = (st_nxt.state != ST_HALT) && (st_nxt.csel == CSEL_INT);
    st_nxt.lvd_en = (st_nxt.state == ST_RUN);
    st_nxt.bod_en = (st_nxt.state == ST_RUN) || (st_nxt.state == ST_RESET);
    st_nxt.tmr_en = (st_nxt.state == ST_RUN) || (st_nxt.state == ST_IDLE);
    st_nxt.xdrv = (st_nxt.csel == CSEL_XTAL) && (st_nxt.state != ST_HALT) &&
                 ~ext_clock_in_i;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      // The start-up count is armed so that release waits out the delay.
      st_r <= '{state: ST_RESET, cnt: CNT_LOAD, div: DIV_ZERO, ext_q: 1'b0,
                tmr: TMR_ZERO, trim: TRIM_RST, csel: CSEL_INT, flag: 1'b0,
                halt_req: 1'b0, idle_req: 1'b0, rdata: DATA_ZERO,
                core_run: 1'b0, io_reset: 1'b1, osc_en: 1'b1,
                lvd_en: 1'b0, bod_en: 1'b1, tmr_en: 1'b0, tick: 1'b0,
                xdrv: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o = st_r.rdata;
  assign core_run_o = st_r.core_run;
  assign io_reset_o = st_r.io_reset;
  assign osc_en_o = st_r.osc_en;
  assign lvd_en_o = st_r.lvd_en;
  assign bod_en_o = st_r.bod_en;
  assign timer0_en_o = st_r.tmr_en;
  assign instr_tick_o = st_r.tick;
  assign ext_clock_out_o = st_r.xdrv;

  property p_flag_follow;
    @(posedge clk_i) disable iff (!rst_b_i)
    (st_r.lvd_en && !any_rst) |=>
      st_r.flag == $past(vcc_below_i[st_r.trim]);
  endproperty
  a_flag_follow: assert property (p_flag_follow)
    else $error("Flag does not follow selected comparator.");

  property p_flag_read;
    @(posedge clk_i) disable iff (!rst_b_i)
    (bus_i.rd && bus_i.addr == OFF_LBAT_CTRL) |=>
      rdata_o[LB_FLAG_BIT] == $past(st_r.flag);
  endproperty
  a_flag_read: assert property (p_flag_read)
    else $error("Flag read value wrong.");

  property p_trim_write;
    @(posedge clk_i) disable iff (!rst_b_i)
    (bus_i.wr && bus_i.addr == OFF_LBAT_CTRL && !any_rst) |=>
      st_r.trim == $past(bus_i.wdata[LB_TRIM_LSB +: LB_TRIM_W]) &&
      $stable(st_r.state);
  endproperty
  a_trim_write: assert property (p_trim_write)
    else $error("Trim write lost or disturbed the mode.");

  property p_reset_hold;
    @(posedge clk_i) disable iff (!rst_b_i)
    any_rst |=> io_reset_o && !core_run_o ##1 io_reset_o;
  endproperty
  a_reset_hold: assert property (p_reset_hold)
    else $error("Reset source did not hold the sequence.");

  property p_int_div;
    @(posedge clk_i) disable iff (!rst_b_i)
    (st_r.core_run && st_r.csel == CSEL_INT && osc_tick_i &&
     st_r.div == DIV_ZERO && !bus_i.wr && !any_rst) |=> !instr_tick_o;
  endproperty
  a_int_div: assert property (p_int_div)
    else $error("Internal clock not divided by two.");

  property p_halt_enter;
    @(posedge clk_i) disable iff (!rst_b_i)
    (st_r.state == ST_RUN && bus_i.wr && bus_i.addr == OFF_PWR_REQ &&
     bus_i.wdata[HALT_REQ_BIT] && !any_rst) |=>
      st_r.state == ST_HALT && !osc_en_o && !lvd_en_o && !bod_en_o;
  endproperty
  a_halt_enter: assert property (p_halt_enter)
    else $error("HALT entry did not shut down subsystems.");

  property p_halt_stay;
    @(posedge clk_i) disable iff (!rst_b_i)
    (st_r.state == ST_HALT && !multi_input_wakeup_i && !any_rst) |=>
      st_r.state == ST_HALT;
  endproperty
  a_halt_stay: assert property (p_halt_stay)
    else $error("HALT left without wakeup event.");

  property p_hwake_wait;
    @(posedge clk_i) disable iff (!rst_b_i)
    (st_r.state == ST_HALT && multi_input_wakeup_i && !any_rst) |=>
      !core_run_o [*2];
  endproperty
  a_hwake_wait: assert property (p_hwake_wait)
    else $error("Execution resumed without start-up delay.");

  property p_idle_enter;
    @(posedge clk_i) disable iff (!rst_b_i)
    (st_r.state == ST_RUN && bus_i.wr && bus_i.addr == OFF_PWR_REQ &&
     bus_i.wdata[IDLE_REQ_BIT] && !bus_i.wdata[HALT_REQ_BIT] && !any_rst)
      |=> st_r.state == ST_IDLE && timer0_en_o && !lvd_en_o && !bod_en_o &&
          (osc_en_o == (st_r.csel == CSEL_INT));
  endproperty
  a_idle_enter: assert property (p_idle_enter)
    else $error("IDLE entry gated the wrong subsystems.");

  property p_idle_wake;
    @(posedge clk_i) disable iff (!rst_b_i)
    (st_r.state == ST_IDLE && ovf && !any_rst) |=>
      core_run_o && !st_r.idle_req;
  endproperty
  a_idle_wake: assert property (p_idle_wake)
    else $error("IDLE wake did not resume on next cycle.");

  property p_osc_run;
    @(posedge clk_i) disable iff (!rst_b_i)
    (st_r.state == ST_RUN) |-> (osc_en_o == (st_r.csel == CSEL_INT));
  endproperty
  a_osc_run: assert property (p_osc_run)
    else $error("Oscillator enable wrong in RUN.");

  property p_square_tick;
    @(posedge clk_i) disable iff (!rst_b_i)
    (st_r.state == ST_RUN && st_r.csel == CSEL_SQUARE && ext_rise) |=>
      instr_tick_o;
  endproperty
  a_square_tick: assert property (p_square_tick)
    else $error("Square input edge gave no instruction tick.");

  property p_halt_clear;
    @(posedge clk_i) disable iff (!rst_b_i)
    (st_r.state == ST_HWAKE && st_r.cnt == CNT_ZERO && !any_rst) |=>
      core_run_o && !st_r.halt_req;
  endproperty
  a_halt_clear: assert property (p_halt_clear)
    else $error("Halt request not cleared on leaving HALT.");

  property p_idle_stay;
    @(posedge clk_i) disable iff (!rst_b_i)
    (st_r.state == ST_IDLE && !ovf && !any_rst) |=> st_r.state == ST_IDLE;
  endproperty
  a_idle_stay: assert property (p_idle_stay)
    else $error("IDLE left without timer overflow.");

endmodule

// ==== inc/pmrc_pkg.sv ====
package pmrc_pkg;

  // Register bus geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets.
  localparam logic [7:0] OFF_LBAT_CTRL = 8'h00;
  localparam logic [7:0] OFF_PWR_REQ = 8'h01;
  localparam logic [7:0] OFF_CLK_SEL = 8'h02;
  localparam logic [7:0] OFF_STATUS = 8'h03;

  // Field positions.
  localparam int LB_FLAG_BIT = 0;
  localparam int LB_TRIM_LSB = 4;
  localparam int LB_TRIM_W = 3;
  localparam int HALT_REQ_BIT = 0;
  localparam int IDLE_REQ_BIT = 1;
  localparam int CSEL_W = 2;
  localparam int NUM_LEVELS = 8;

  // Reset values.
  localparam logic [2:0] TRIM_RST = 3'h0;
  localparam logic [7:0] DATA_ZERO = 8'h00;

  // Clock source codes.
  localparam logic [1:0] CSEL_INT = 2'h0;
  localparam logic [1:0] CSEL_SQUARE = 2'h1;
  localparam logic [1:0] CSEL_XTAL = 2'h2;
  localparam logic [1:0] CSEL_RC = 2'h3;

  // Dividers and timer.
  localparam logic [1:0] DIV_INT_LAST = 2'h1;
  localparam logic [1:0] DIV_EXT_LAST = 2'h3;
  localparam logic [1:0] DIV_ZERO = 2'h0;
  localparam int TMR_W = 13;
  localparam logic [12:0] TMR_LAST = 13'h1FFF;
  localparam logic [12:0] TMR_ZERO = 13'h0000;

  // Start-up delay: 1 ms at 100 MHz.
  localparam int CLK_MHZ = 100;
  localparam int STARTUP_US = 1000;
  localparam int STARTUP_CYC_DEF = STARTUP_US * CLK_MHZ;
  localparam int CNT_W = 17;
  localparam logic [16:0] CNT_ZERO = 17'h00000;

  typedef enum logic [4:0] {
    ST_RESET = 5'b00001,
    ST_RUN = 5'b00010,
    ST_HALT = 5'b00100,
    ST_HWAKE = 5'b01000,
    ST_IDLE = 5'b10000
  } pmrc_state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pmrc_bus_s;

  typedef struct packed {
    logic por;
    logic brownout_reset;
    logic wdog;
    logic ext_reset_b;
  } pmrc_rst_src_s;

endpackage

// ==== dv/pmrc_tb.sv ====
`timescale 1ns/100ps
module testbench;
  import pmrc_pkg::*;
  localparam int SU = 8;
  localparam int LIMIT = 90000;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  pmrc_bus_s bus_i = '0;
  logic [7:0] rdata_o;
  logic [7:0] vcc_below_i = 8'h00;
  pmrc_rst_src_s rst_src_i = 4'h1;
  logic multi_input_wakeup_i = 1'b0;
  logic osc_tick_i = 1'b0;
  logic ext_clock_in_i = 1'b0;
  logic core_run_o, io_reset_o, osc_en_o, lvd_en_o;
  logic bod_en_o, timer0_en_o, instr_tick_o, ext_clock_out_o;
  logic osc_free = 1'b0;
  logic ext_free = 1'b0;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int ticks = 0;
  int n, t0, t1;

  pmrc_top #(.STARTUP_CYC(SU)) i_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .vcc_below_i(vcc_below_i), .rst_src_i(rst_src_i),
    .multi_input_wakeup_i(multi_input_wakeup_i), .osc_tick_i(osc_tick_i),
    .ext_clock_in_i(ext_clock_in_i), .core_run_o(core_run_o),
    .io_reset_o(io_reset_o), .osc_en_o(osc_en_o), .lvd_en_o(lvd_en_o),
    .bod_en_o(bod_en_o), .timer0_en_o(timer0_en_o),
    .instr_tick_o(instr_tick_o), .ext_clock_out_o(ext_clock_out_o));

  always #5 clk_i = ~clk_i;

  // Oscillator and external clock make one-cycle pulses when enabled.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (instr_tick_o === 1'b1) ticks <= ticks + 1;
    osc_tick_i <= osc_free & ~osc_tick_i;
    ext_clock_in_i <= ext_free & ~ext_clock_in_i;
    if (cyc == LIMIT) begin
      err_count = err_count + 1;
      summarize();
    end
  end

  task summarize();
    if (err_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus_i <= {1'b1, 1'b0, a, d};
    @(posedge clk_i);
    bus_i <= '0;
  endtask

  task rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    bus_i <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clk_i);
    bus_i <= '0;
    #1;
    chk(rdata_o, exp, "read data");
  endtask

  task wait_run(input int lim, output int c);
    c = 0;
    while (core_run_o !== 1'b1 && c < lim) begin
      @(posedge clk_i);
      #1;
      c++;
    end
  endtask

  task wake();
    @(posedge clk_i);
    multi_input_wakeup_i <= 1'b1;
    @(posedge clk_i);
    multi_input_wakeup_i <= 1'b0;
  endtask

  task run_chk(input int n);
    chk(8'(n >= SU && n <= SU + 4), 8'h01, "start-up length");
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    wait_run(100, n);
    run_chk(n);
    chk(8'(io_reset_o), 8'h00, "io reset");
    rdc(OFF_LBAT_CTRL, 8'h00);
    rdc(OFF_PWR_REQ, 8'h00);
    rdc(OFF_CLK_SEL, 8'h00);
    rdc(OFF_STATUS, 8'h02);
    rdc(8'h7F, 8'h00);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_i);
      vcc_below_i <= 8'h01 << k;
      wr(OFF_LBAT_CTRL, {1'b1, 3'(k), 4'hF});
      rdc(OFF_LBAT_CTRL, {1'b0, 3'(k), 4'h1});
      @(posedge clk_i);
      vcc_below_i <= ~(8'h01 << k);
      rdc(OFF_LBAT_CTRL, {1'b0, 3'(k), 4'h0});
    end
    chk(8'(core_run_o), 8'h01, "run");
    for (int m = 0; m < 4; m++) begin
      wr(OFF_CLK_SEL, 8'(m));
      t0 = ticks;
      @(posedge clk_i);
      if (m == 0) osc_free <= 1'b1;
      else ext_free <= 1'b1;
      repeat (32) @(posedge clk_i);
      osc_free <= 1'b0;
      ext_free <= 1'b0;
      repeat (4) @(posedge clk_i);
      #1;
      n = (m == 0) ? 8 : (m == 1) ? 16 : 4;
      chk(8'(ticks - t0), 8'(n), "ticks");
      chk(8'(osc_en_o), 8'(m == 0), "osc enable");
      chk(8'(ext_clock_out_o), 8'(m == 2), "crystal drive");
    end
    wr(OFF_CLK_SEL, 8'h00);
    wake();
    @(posedge clk_i);
    #1;
    chk(8'(core_run_o), 8'h01, "run");
    wr(OFF_PWR_REQ, 8'h01);
    @(posedge clk_i);
    #1;
    chk({core_run_o, osc_en_o, lvd_en_o, bod_en_o, timer0_en_o}, 8'h00,
        "halt outputs");
    @(posedge clk_i);
    vcc_below_i <= 8'hFF;
    repeat (3) @(posedge clk_i);
    rdc(OFF_LBAT_CTRL, 8'h70);
    rdc(OFF_STATUS, 8'h04);
    rdc(OFF_PWR_REQ, 8'h00);
    repeat (20) @(posedge clk_i);
    #1;
    chk(8'(core_run_o), 8'h00, "halt holds");
    wake();
    wait_run(100, n);
    run_chk(n);
    rdc(OFF_STATUS, 8'h02);
    wr(OFF_PWR_REQ, 8'h00);
    @(posedge clk_i);
    vcc_below_i <= 8'h00;
    wr(OFF_PWR_REQ, 8'h03);
    rdc(OFF_STATUS, 8'h04);
    wake();
    wait_run(100, n);
    run_chk(n);
    @(posedge clk_i);
    multi_input_wakeup_i <= 1'b0;
    osc_free <= 1'b1;
    wr(OFF_PWR_REQ, 8'h02);
    @(posedge clk_i);
    #1;
    chk({core_run_o, osc_en_o, lvd_en_o, bod_en_o, timer0_en_o}, 8'h09,
        "idle outputs");
    rdc(OFF_STATUS, 8'h10);
    t0 = ticks;
    wait_run(40000, n);
    chk(8'(ticks - t0 <= 8192 && n < 40000), 8'h01, "idle wake");
    t1 = ticks;
    rdc(OFF_PWR_REQ, 8'h00);
    wr(OFF_PWR_REQ, 8'h02);
    @(posedge clk_i);
    // Supply drops while the detector is off; the flag picks it up once RUN turns the detector back on.
    vcc_below_i <= 8'hFF;
    #1;
    wait_run(40000, n);
    chk(8'(ticks - t1 == 8192), 8'h01, "idle period");
    rdc(OFF_STATUS, 8'h02);
    osc_free <= 1'b0;
    repeat (1000) @(posedge clk_i);
    rdc(OFF_LBAT_CTRL, 8'h71);
    @(posedge clk_i);
    vcc_below_i <= 8'h00;
    for (int s = 0; s < 4; s++) begin
      wr(OFF_LBAT_CTRL, 8'h30);
      wr(OFF_CLK_SEL, 8'h02);
      @(posedge clk_i);
      rst_src_i <= (4'h8 >> s) ^ 4'h1;
      repeat (3) @(posedge clk_i);
      #1;
      chk({core_run_o, io_reset_o}, 8'h01, "reset outputs");
      @(posedge clk_i);
      rst_src_i <= 4'h1;
      wait_run(100, n);
      run_chk(n);
      rdc(OFF_LBAT_CTRL, 8'h00);
      rdc(OFF_CLK_SEL, 8'h00);
    end
    summarize();
  end
endmodule
